// file: include/acc_pkg.sv
// shared constants and carrier types for the analog compare control block
// assumes a single 200 MHz clock and an AXI4-Lite register bus of 32-bit words
package acc_pkg;

	// printed offsets are not multiples of four: kept as indices, byte address = 4*index
	localparam logic [7:0] IDX_CTL_ONE  = 8'h59;
	localparam logic [7:0] IDX_CTL_TWO  = 8'h5A;
	localparam logic [7:0] IDX_PIN_DIS  = 8'h5B;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h5C;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'h5D;
	localparam logic [7:0] IDX_IRQ_EN   = 8'h5E;
	localparam int         ADDR_W       = 12;

	// control one fields
	localparam int BIT_EXCH   = 7;
	localparam int BIT_RSEL   = 6;
	localparam int BIT_REF_HI = 5;
	localparam int BIT_REF_LO = 4;
	localparam int BIT_PWR    = 3;
	localparam int BIT_EDGE   = 2;
	localparam int BIT_IE     = 1;
	localparam int BIT_FLAG   = 0;
	// control two fields
	localparam int BIT_SHORT  = 7;
	localparam int BIT_PSEL_HI = 6;
	localparam int BIT_PSEL_LO = 2;
	localparam int BIT_FILT   = 1;
	localparam int BIT_RESULT = 0;
	// event status fields
	localparam int BIT_EV_RISE = 0;
	localparam int BIT_EV_FALL = 1;

	localparam logic [7:0] CTL_ONE_RST = 8'h00;
	localparam logic [7:0] CTL_TWO_RST = 8'h00;
	localparam logic [7:0] PIN_DIS_RST = 8'h00;
	localparam logic [1:0] EV_RST      = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		REF_OFF     = 2'h0,
		REF_QUARTER = 2'h1,
		REF_HALF    = 2'h2,
		REF_DIODE   = 2'h3
	} acc_ref_t;

	// analog front end steering
	typedef struct packed {
		logic     pwrOn;
		logic     exchange;
		logic     shortInputs;
		logic     refOnMinus;
		acc_ref_t refLevel;
		logic [4:0] pinSelect;
		logic     filterSel;
	} acc_analog_t;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} acc_wr_state_t;

	typedef struct packed {
		logic [7:0]    ctlOne;
		logic [7:0]    ctlTwo;
		logic [7:0]    pinDis;
		logic [1:0]    evStat;
		logic [1:0]    evEn;
		logic          prevOut;
		logic          awHeld;
		logic [ADDR_W-1:0] awAddr;
		logic          wHeld;
		logic [31:0]   wData;
		logic [3:0]    wStrb;
		acc_wr_state_t wrState;
		logic [1:0]    bResp;
		logic          rValid;
		logic [31:0]   rData;
		logic [1:0]    rResp;
	} acc_state_t;

endpackage

// file: rtl/acc_analog_compare_control.sv
// digital control around an analog comparator, with AXI4-Lite registers
// assumes the analog model turns acc_analog_t into rawCompare and filteredCompare,
// and that an interrupt controller pulses irqServiced when the request is taken
//
// Functional notes
// - powered result high when plus terminal exceeds minus terminal, else low
// - software switches comparator on or off by the power bit
// - power bit clear forces the result low
// - exchange bit swaps signals feeding plus and minus terminals
// - exchange bit also inverts the comparator output
// - filter select bit routes output through the filter path
// - input short bit closes switch joining the two terminals
// - reference level field drives reference; select bit chooses its terminal
// - level codes: 00 off, 01 quarter, 10 half, 11 diode
// - input pin select bits connect each terminal to pins independently
// - each set buffer disable bit disables that pin's input and output buffers
// - a pin selected as comparator input has its buffers disabled regardless; code forces only pins 0 and 1, from select bits 2 and 3
// - event flag sets on the comparator edge chosen by polarity bit
// - polarity bit 0 selects rising edge, 1 selects falling edge
// - request raised only while flag, local and global enables all set
// - flag clears when request is serviced; software may also clear it
// - comparator result drives the timer capture input
// - three byte registers at consecutive addresses, cleared at reset
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module acc_analog_compare_control
	import acc_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                rawCompare,
	input  wire logic                filteredCompare,
	input  wire logic                globalIrqEnable,
	input  wire logic                irqServiced,
	output acc_pkg::acc_analog_t     analogCtl,
	output logic [7:0]               pinBufferOff,
	output logic                     timerCaptureInput,
	output logic                     compareIrq,
	output logic                     eventIrq
);
	import acc_pkg::*;

	acc_state_t st;
	acc_state_t next_st;
	logic       finalOut;
	logic       rise;
	logic       fall;
	logic       edgeHit;
	logic       wrFire;
	logic       rdFire;
	logic [7:0] wrIdx;
	logic [7:0] rdIdx;
	logic [7:0] ctlTwoMerged;

	function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
		word_index = a[9:2];
	endfunction

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
	                                          input logic [3:0] s);
		merge_byte = s[0] ? d[7:0] : old;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// analog steering and result path

	// exchange swaps terminals in the analog mux
	// pin select drives the input switches
	always_comb begin
		analogCtl.pwrOn       = st.ctlOne[BIT_PWR];
		analogCtl.exchange    = st.ctlOne[BIT_EXCH];
		analogCtl.shortInputs = st.ctlTwo[BIT_SHORT];
		// reference sits opposite the signal terminal once exchanged
		analogCtl.refOnMinus  = st.ctlOne[BIT_RSEL] ^ st.ctlOne[BIT_EXCH];
		// level code passes straight to the ladder
		analogCtl.refLevel    = acc_ref_t'(st.ctlOne[BIT_REF_HI:BIT_REF_LO]);
		analogCtl.pinSelect   = st.ctlTwo[BIT_PSEL_HI:BIT_PSEL_LO];
		analogCtl.filterSel   = st.ctlTwo[BIT_FILT];
	end

	// raw or filtered result from the analog model
	// one final output for all users
	assign finalOut = st.ctlOne[BIT_PWR]
	                & ((st.ctlTwo[BIT_FILT] ? filteredCompare : rawCompare)
	                   ^ st.ctlOne[BIT_EXCH]);

	assign timerCaptureInput = finalOut;

	always_comb begin
		pinBufferOff = st.pinDis;
		pinBufferOff[0] = st.pinDis[0] | st.ctlTwo[BIT_PSEL_LO];
		pinBufferOff[1] = st.pinDis[1] | st.ctlTwo[BIT_PSEL_LO + 1];
	end

	assign rise    = finalOut & ~st.prevOut;
	assign fall    = ~finalOut & st.prevOut;
	assign edgeHit = st.ctlOne[BIT_EDGE] ? fall : rise;

	// request needs flag and both enables
	assign compareIrq = st.ctlOne[BIT_FLAG] & st.ctlOne[BIT_IE] & globalIrqEnable;
	assign eventIrq   = |(st.evStat & st.evEn);

	////////////////////////////////////////////////////////////////////////////////
	// bus handshakes

	assign s_axi_awready = ~st.awHeld & (st.wrState == WR_IDLE);
	assign s_axi_wready  = ~st.wHeld & (st.wrState == WR_IDLE);
	assign s_axi_bvalid  = (st.wrState == WR_RESP);
	assign s_axi_bresp   = st.bResp;
	assign s_axi_arready = ~st.rValid;
	assign s_axi_rvalid  = st.rValid;
	assign s_axi_rdata   = st.rData;
	assign s_axi_rresp   = st.rResp;

	assign wrFire = st.awHeld & st.wHeld & (st.wrState == WR_IDLE);
	assign rdFire = s_axi_arvalid & s_axi_arready;
	assign wrIdx  = word_index(st.awAddr);
	assign rdIdx  = word_index(s_axi_araddr);
	assign ctlTwoMerged = merge_byte(st.ctlTwo, st.wData, st.wStrb);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		next_st.prevOut = finalOut;

		if (s_axi_awvalid && s_axi_awready) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end

		if (irqServiced) begin
			next_st.ctlOne[BIT_FLAG] = 1'b0;
		end

		if (wrFire) begin
			next_st.awHeld  = 1'b0;
			next_st.wHeld   = 1'b0;
			next_st.wrState = WR_RESP;
			next_st.bResp   = RESP_OKAY;
			unique case (wrIdx)
				IDX_CTL_ONE: begin
					next_st.ctlOne = merge_byte(st.ctlOne, st.wData, st.wStrb);
				end
				IDX_CTL_TWO: begin
					// result bit is read only
					next_st.ctlTwo = {ctlTwoMerged[7:1], 1'b0};
				end
				IDX_PIN_DIS: begin
					next_st.pinDis = merge_byte(st.pinDis, st.wData, st.wStrb);
				end
				IDX_IRQ_CLR: begin
					if (st.wStrb[0]) begin
						next_st.evStat = st.evStat & ~st.wData[1:0];
					end
				end
				IDX_IRQ_EN: begin
					if (st.wStrb[0]) begin
						next_st.evEn = st.wData[1:0];
					end
				end
				IDX_IRQ_STAT: begin
				end
				default: begin
					next_st.bResp = RESP_SLVERR;
				end
			endcase
		end

		if ((st.wrState == WR_RESP) && s_axi_bready) begin
			next_st.wrState = WR_IDLE;
		end

		// hardware sets win over any clear in the same cycle
		// edge sets flag
		if (edgeHit) begin
			next_st.ctlOne[BIT_FLAG] = 1'b1;
		end
		if (rise) begin
			next_st.evStat[BIT_EV_RISE] = 1'b1;
		end
		if (fall) begin
			next_st.evStat[BIT_EV_FALL] = 1'b1;
		end

		if (st.rValid && s_axi_rready) begin
			next_st.rValid = 1'b0;
		end
		if (rdFire) begin
			next_st.rValid = 1'b1;
			next_st.rResp  = RESP_OKAY;
			next_st.rData  = 32'h0000_0000;
			unique case (rdIdx)
				IDX_CTL_ONE:  next_st.rData[7:0] = st.ctlOne;
				IDX_CTL_TWO:  next_st.rData[7:0] = {st.ctlTwo[7:1], finalOut};
				IDX_PIN_DIS:  next_st.rData[7:0] = st.pinDis;
				IDX_IRQ_STAT: next_st.rData[1:0] = st.evStat;
				IDX_IRQ_CLR:  next_st.rData[1:0] = 2'h0;
				IDX_IRQ_EN:   next_st.rData[1:0] = st.evEn;
				default:      next_st.rResp      = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st         <= '0;
			st.ctlOne  <= CTL_ONE_RST;
			st.ctlTwo  <= CTL_TWO_RST;
			st.pinDis  <= PIN_DIS_RST;
			st.evStat  <= EV_RST;
			st.evEn    <= EV_RST;
			st.wrState <= WR_IDLE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_power_gate_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st.ctlOne[BIT_PWR] |-> !timerCaptureInput) else $error("result high while off");
	chk_exchange_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_PWR] && !st.ctlTwo[BIT_FILT] |->
		timerCaptureInput == (rawCompare ^ st.ctlOne[BIT_EXCH])) else $error("bad inversion");
	chk_filter_path: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_PWR] && !st.ctlOne[BIT_EXCH] && st.ctlTwo[BIT_FILT] |->
		timerCaptureInput == filteredCompare) else $error("filter path wrong");
	chk_pin_select_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlTwo[BIT_PSEL_LO] |-> pinBufferOff[0]) else $error("selected pin buffer on");
	chk_pin_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pinBufferOff & st.pinDis) == st.pinDis) else $error("buffer not disabled");
	chk_rise_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st.ctlOne[BIT_EDGE] && !st.prevOut && finalOut |=> st.ctlOne[BIT_FLAG])
		else $error("rising edge missed");
	chk_fall_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_EDGE] && $fell(finalOut) && $past(st.ctlOne[BIT_EDGE]) |=>
		st.ctlOne[BIT_FLAG]) else $error("falling edge missed");
	chk_irq_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
		compareIrq |-> st.ctlOne[BIT_FLAG] && st.ctlOne[BIT_IE] && globalIrqEnable)
		else $error("request without enables");
	chk_service_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		irqServiced && !edgeHit && !wrFire |=> !st.ctlOne[BIT_FLAG])
		else $error("flag kept after service");
	chk_reset_clear: assert property (@(posedge core_clk)
		!rst_n |=> st.ctlOne == 8'h00 && st.pinDis == 8'h00) else $error("reset not cleared");
	chk_raw_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_PWR] && !st.ctlOne[BIT_EXCH] && !st.ctlTwo[BIT_FILT] |->
		timerCaptureInput == rawCompare) else $error("raw result wrong");
	chk_power_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.pwrOn == st.ctlOne[BIT_PWR]) else $error("power control wrong");
	chk_exchange_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.exchange == st.ctlOne[BIT_EXCH]) else $error("exchange control wrong");
	chk_exchange_sense: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_PWR] && st.ctlOne[BIT_EXCH] && !st.ctlTwo[BIT_FILT] |->
		timerCaptureInput == !rawCompare) else $error("exchanged result not inverted");
	chk_filter_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.filterSel == st.ctlTwo[BIT_FILT]) else $error("filter control wrong");
	chk_short_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.shortInputs == st.ctlTwo[BIT_SHORT]) else $error("short control wrong");
	chk_ref_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st.ctlOne[BIT_EXCH] |-> analogCtl.refOnMinus == st.ctlOne[BIT_RSEL])
		else $error("reference terminal wrong");
	chk_ref_exchanged: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_EXCH] |-> analogCtl.refOnMinus != st.ctlOne[BIT_RSEL])
		else $error("exchanged reference terminal wrong");
	chk_ref_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.refLevel == st.ctlOne[BIT_REF_HI:BIT_REF_LO]) else $error("level code wrong");
	chk_pin_select_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		analogCtl.pinSelect == st.ctlTwo[BIT_PSEL_HI:BIT_PSEL_LO]) else $error("pin select wrong");
	chk_pin_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
		pinBufferOff[7:2] == st.pinDis[7:2]) else $error("upper pin buffer wrong");
	chk_pin1_select_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlTwo[BIT_PSEL_LO + 1] |-> pinBufferOff[1]) else $error("pin one buffer on");
	chk_edge_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		edgeHit |=> st.ctlOne[BIT_FLAG]) else $error("edge lost against clear");
	chk_flag_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		!edgeHit && !irqServiced && !wrFire |=> $stable(st.ctlOne[BIT_FLAG]))
		else $error("flag changed without cause");
	chk_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlOne[BIT_FLAG] && st.ctlOne[BIT_IE] && globalIrqEnable |-> compareIrq)
		else $error("request missing");
	chk_event_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st.evStat & st.evEn) != 2'h0 |-> eventIrq) else $error("event request missing");
	chk_result_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctlTwo[BIT_RESULT] == 1'b0) else $error("result bit stored");
	chk_rise_status: assert property (@(posedge core_clk) disable iff (!rst_n)
		rise |=> st.evStat[BIT_EV_RISE]) else $error("rising status missed");
	chk_fall_status: assert property (@(posedge core_clk) disable iff (!rst_n)
		fall |=> st.evStat[BIT_EV_FALL]) else $error("falling status missed");
	chk_write_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrFire |=> s_axi_bvalid) else $error("write response missing");

endmodule

// file: testbench/acc_analog_compare_control_tb.sv
// self-checking bench for the analog compare control block
// assumes the analog model stands in for comparator, filter and reference
`timescale 1ns/1ps
module acc_analog_compare_control_tb;
	import acc_pkg::*;
	logic              core_clk = 1'h0;
	logic              rst_n = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic              s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	logic              rawCompare, filteredCompare, globalIrqEnable, irqServiced;
	logic              timerCaptureInput, compareIrq, eventIrq;
	acc_analog_t       analogCtl;
	logic [7:0]        pinBufferOff, pinPlus, pinMinus, r, r2;
	logic [7:0]        refTab [4] = '{8'hC0, 8'h40, 8'h80, 8'h8C};
	logic [33:0]       rq [$];
	logic [1:0]        bq [$];
	int                n_fail = 0;
	int                compares = 0;
	int                seed = 32'h43F58DAD;
	int                i, j;

	acc_analog_compare_control u_acc_analog_compare_control (.*);
	acc_analog_model u_acc_analog_model (.*);

	always #2.5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic ck(input logic [33:0] s, input logic [33:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic late();
		n_fail++;
		wrap_up();
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	task automatic setv(input logic [7:0] p, input logic [7:0] m);
		pinPlus <= p;
		pinMinus <= m;
		idle(2);
	endtask

	// both channels offered together, each released when taken
	task automatic wr(input logic [7:0] x, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
		logic a = 1'h1;
		logic w = 1'h1;
		logic b = 1'h1;
		bq.push_back(e);
		s_axi_awaddr <= {2'h0, x, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int k = 0; k < 40 && b; k++) begin
			@(posedge core_clk);
			if (a && s_axi_awready) begin
				a = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			// bready stays up: dropping it here would clash with the next raise
			if (s_axi_bvalid) begin
				b = 1'h0;
			end
		end
		if (b) late();
	endtask

	task automatic rd(input logic [7:0] x, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
		logic a = 1'h1;
		logic b = 1'h1;
		rq.push_back({e, 24'h0, d});
		s_axi_araddr <= {2'h0, x, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int k = 0; k < 40 && b; k++) begin
			@(posedge core_clk);
			if (a && s_axi_arready) begin
				a = 1'h0;
				s_axi_arvalid <= 1'h0;
			end
			if (s_axi_rvalid) begin
				b = 1'h0;
			end
		end
		if (b) late();
	endtask

	// answers are matched against the oldest note as they appear
	always @(posedge core_clk) begin
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			ck(34'(s_axi_bresp), 34'(bq.pop_front()));
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
			ck({s_axi_rresp, s_axi_rdata}, rq.pop_front());
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, pinPlus, pinMinus} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, globalIrqEnable, irqServiced} = '0;
		idle(5);
		rst_n <= 1'h1;
		ck(34'(timerCaptureInput), 34'h0);
		rd(IDX_CTL_ONE, CTL_ONE_RST);
		rd(IDX_CTL_TWO, CTL_TWO_RST);
		rd(IDX_PIN_DIS, PIN_DIS_RST);
		rd(IDX_IRQ_STAT, 8'h00);
		rd(8'h10, 8'h00, RESP_SLVERR);
		wr(8'h10, 8'hFF, RESP_SLVERR);
		rd(IDX_IRQ_CLR, 8'h00);
		for (i = 0; i < 4; i++) begin
			r = 8'($random(seed));
			r2 = 8'($random(seed)) & 8'hFC;
			wr(IDX_PIN_DIS, r);
			rd(IDX_PIN_DIS, r);
			wr(IDX_CTL_TWO, r2);
			rd(IDX_CTL_TWO, r2);
			ck(34'(pinBufferOff), 34'(r | {6'h0, r2[3:2]}));
			ck(34'(analogCtl.pinSelect), 34'(r2[6:2]));
			ck(34'(analogCtl.shortInputs), 34'(r2[7]));
		end
		wr(IDX_CTL_TWO, 8'h00);
		// lane 0 strobe low leaves the register alone
		s_axi_wstrb <= 4'hE;
		wr(IDX_PIN_DIS, ~r);
		rd(IDX_PIN_DIS, r);
		s_axi_wstrb <= 4'hF;
		for (i = 0; i < 8; i++) begin
			r = 8'($random(seed));
			r2 = 8'($random(seed));
			// equal levels read differently once exchanged
			if (r2 == r) r2 = ~r;
			wr(IDX_CTL_ONE, {i[0], 7'h08});
			setv(r, r2);
			ck(34'(analogCtl.exchange), 34'(i[0]));
			ck(34'(timerCaptureInput), 34'(r > r2));
			rd(IDX_CTL_TWO, {7'h0, r > r2});
		end
		wr(IDX_CTL_ONE, 8'h80);
		setv(8'hF0, 8'h10);
		ck(34'(timerCaptureInput), 34'h0);
		wr(IDX_CTL_TWO, 8'h02);
		wr(IDX_CTL_ONE, 8'h08);
		ck(34'(analogCtl.filterSel), 34'h1);
		ck(34'(analogCtl.pwrOn), 34'h1);
		setv(8'h10, 8'hF0);
		idle(4);
		setv(8'hF0, 8'h10);
		ck(34'(timerCaptureInput), 34'h0);
		idle(4);
		ck(34'(timerCaptureInput), 34'h1);
		wr(IDX_CTL_TWO, 8'h00);
		// exchange moves the reference to the other terminal
		wr(IDX_CTL_ONE, 8'hC8);
		ck(34'(analogCtl.refOnMinus), 34'h0);
		// each level on the minus side
		for (i = 0; i < 4; i++) begin
			wr(IDX_CTL_ONE, {2'h1, i[1:0], 4'h8});
			ck(34'(analogCtl.refLevel), 34'(i[1:0]));
			ck(34'(analogCtl.refOnMinus), 34'h1);
			for (j = 0; j < 2; j++) begin
				setv(j[0] ? refTab[i] + 8'h1 : refTab[i] - 8'h1, 8'hC0);
				ck(34'(timerCaptureInput), 34'(j[0]));
			end
		end
		wr(IDX_CTL_TWO, 8'h80);
		setv(8'hF0, 8'h10);
		ck(34'(timerCaptureInput), 34'h0);
		wr(IDX_CTL_TWO, 8'h00);
		setv(8'h10, 8'hF0);
		wr(IDX_IRQ_CLR, 8'h03);
		wr(IDX_CTL_ONE, 8'h0A);
		globalIrqEnable <= 1'h1;
		setv(8'hF0, 8'h10);
		idle(2);
		rd(IDX_CTL_ONE, 8'h0B);
		ck(34'(compareIrq), 34'h1);
		globalIrqEnable <= 1'h0;
		idle(1);
		ck(34'(compareIrq), 34'h0);
		globalIrqEnable <= 1'h1;
		irqServiced <= 1'h1;
		idle(1);
		irqServiced <= 1'h0;
		idle(2);
		ck(34'(compareIrq), 34'h0);
		wr(IDX_CTL_ONE, 8'h0E);
		setv(8'h10, 8'hF0);
		idle(2);
		rd(IDX_CTL_ONE, 8'h0F);
		wr(IDX_CTL_ONE, 8'h0E);
		setv(8'hF0, 8'h10);
		idle(2);
		rd(IDX_CTL_ONE, 8'h0E);
		// sticky events, enable and clear
		rd(IDX_IRQ_STAT, 8'h03);
		ck(34'(eventIrq), 34'h0);
		wr(IDX_IRQ_EN, 8'h02);
		ck(34'(eventIrq), 34'h1);
		wr(IDX_IRQ_CLR, 8'h02);
		ck(34'(eventIrq), 34'h0);
		rd(IDX_IRQ_STAT, 8'h01);
		idle(3);
		wrap_up();
	end
endmodule

// file: testbench/acc_analog_model.sv
// behavioural comparator, reference ladder and rc filter behind the block
// assumes pin levels come from the bench as 8-bit codes of the supply
`timescale 1ns/1ps
module acc_analog_model
	import acc_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire acc_pkg::acc_analog_t analogCtl,
	input  wire logic [7:0]           pinPlus,
	input  wire logic [7:0]           pinMinus,
	output logic                      rawCompare,
	output logic                      filteredCompare
);
	logic [7:0] refV;
	logic [7:0] termP;
	logic [7:0] termM;
	logic [3:0] rc;
	always_comb begin
		case (analogCtl.refLevel)
			REF_QUARTER: refV = 8'h40;
			REF_HALF:    refV = 8'h80;
			default:     refV = 8'h8C;
		endcase
	end
	always_comb begin
		termP = analogCtl.exchange ? pinMinus : pinPlus;
		termM = analogCtl.exchange ? pinPlus : pinMinus;
		if (analogCtl.refLevel != REF_OFF) begin
			if (analogCtl.refOnMinus)
				termM = refV;
			else
				termP = refV;
		end
	end
	assign rawCompare = !analogCtl.shortInputs && (termP > termM);
	always_ff @(posedge core_clk) begin
		rc <= {rc[2:0], rawCompare};
	end
	assign filteredCompare = rc[3];
endmodule
